// ===== crx_evt_timer.sv
// Shared constants of the receive block and its per-channel event timer
`timescale 1ns/100ps
`default_nettype none

package crx_pkg;
	localparam int CRX_NUM_RPDO = 5;
	localparam int CRX_NUM_EXTRA = 4;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CRX_CLK_KHZ = 200000;
	localparam int CRX_BASE_MS = 5;
	localparam int CRX_BASE_CYC = CRX_BASE_MS * CRX_CLK_KHZ;
	localparam int CRX_PROC_MS = 20;
	localparam int CRX_PROC_TICKS = CRX_PROC_MS / CRX_BASE_MS;
	localparam int CRX_DIV_W = 20;
	localparam int CRX_UNITS_W = 14;
	// ------------------------------------------------------------
	// Reset values, limits and identifiers
	// ------------------------------------------------------------
	localparam logic [31:0] CRX_COMM_RST = 32'h8000_0000;
	localparam logic [15:0] CRX_EVT_RST = 16'h07D0;
	localparam logic [15:0] CRX_EVT_MAX = 16'hFFDC;
	localparam logic [6:0] CRX_NODE_RST = 7'h01;
	localparam int CRX_VALID_BIT = 31;
	localparam int CRX_ZERO_HI = 28;
	localparam int CRX_ZERO_LO = 11;
	localparam logic [10:0] CRX_SDO_RX_BASE = 11'h600;
	localparam logic [10:0] CRX_SDO_TX_BASE = 11'h580;
	// ------------------------------------------------------------
	// Register word indices, byte address is four times the index
	// ------------------------------------------------------------
	localparam logic [4:0] CRX_W_NODE = 5'h00;
	localparam logic [4:0] CRX_W_EXTRA = 5'h01;
	localparam logic [4:0] CRX_W_COMM = 5'h05;
	localparam logic [4:0] CRX_W_EVT = 5'h0A;
	localparam logic [4:0] CRX_W_ROUTE = 5'h0F;
	localparam logic [4:0] CRX_W_STATUS = 5'h10;
	localparam logic [4:0] CRX_W_MASK = 5'h11;
	localparam logic [4:0] CRX_W_EXIST = 5'h12;

	// Milliseconds rounded up to whole 5 ms units
	function automatic logic [13:0] crx_units(input logic [15:0] ms);
		logic [16:0] sum;
		sum = {1'b0, ms} + 17'h00004;
		return 14'(sum / 17'h00005);
	endfunction

	// Bit 5 flags a mapped word, bits 4:0 give its index
	function automatic logic [5:0] crx_word(input logic [7:0] a);
		logic ok;
		ok = (a[1:0] == 2'h0) && (a[7:2] <= {1'b0, CRX_W_EXIST});
		return {ok, a[6:2]};
	endfunction
endpackage

module crx_evt_timer import crx_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic tick,
	input wire logic restart,
	input wire logic [13:0] limit,
	output logic expired
);
	typedef struct packed {
		logic [13:0] cnt;
		logic armed;
		logic expired;
	} crx_tmr_type;

	crx_tmr_type s;
	crx_tmr_type next_s;

	// Armed by a reception; a zero limit never expires.
	// The partial tick after a reception is not counted, so expiry is
	// late by up to one tick but never early
	always_comb begin
		next_s = s;
		next_s.expired = 1'b0;
		if (restart) begin
			next_s.cnt = '0;
			next_s.armed = 1'b1;
		end else if (tick && s.armed && limit != '0) begin
			if (s.cnt >= limit) begin
				next_s.expired = 1'b1;
				next_s.armed = 1'b0;
			end else begin
				next_s.cnt = s.cnt + 14'h0001;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign expired = s.expired;

	property p_tmr_cause;
		@(posedge pclk) disable iff (!presetn)
		expired |-> $past(tick) && $past(s.armed) && !$past(restart);
	endproperty
	a_tmr_cause: assert property (p_tmr_cause) else $error("timer fired without tick");
endmodule // crx_evt_timer

`default_nettype wire

// ===== crx_node.sv
// CAN receive side: SDO channel matching, receive PDO config, timeouts
`timescale 1ns/100ps
`default_nettype none

module crx_node import crx_pkg::*; #(
	parameter int unsigned BASE_TICK_CYC = CRX_BASE_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire logic nmt_operational,
	input wire logic rx_valid,
	input wire logic [10:0] rx_id,
	input wire logic [63:0] rx_data,
	output logic sdo_req,
	output logic [2:0] sdo_chan,
	output logic [10:0] sdo_reply_id,
	output logic [63:0] sdo_data,
	output logic pdo_strobe,
	output logic [2:0] pdo_index,
	output logic [1:0] pdo_route,
	output logic [63:0] pdo_data,
	output logic [4:0] pdo_exist
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef enum logic {CRX_IDLE, CRX_SCAN} crx_scan_type;

	typedef struct packed {
		logic [6:0] node_id;
		logic [3:0][6:0] extra_id;
		logic [4:0][31:0] comm;
		logic [4:0][15:0] evt_ms;
		logic [4:0][1:0] route;
		logic [9:0] status;
		logic [9:0] mask;
		logic [4:0] exist;
		logic [4:0] pend;
		logic [4:0][63:0] held;
		logic [CRX_DIV_W-1:0] div_cnt;
		logic tick5;
		logic [1:0] sub_cnt;
		crx_scan_type scan;
		logic [2:0] idx;
		logic [31:0] prdata;
		logic sdo_req;
		logic [2:0] sdo_chan;
		logic [10:0] sdo_reply_id;
		logic [63:0] sdo_data;
		logic pdo_strobe;
		logic [2:0] pdo_index;
		logic [1:0] pdo_route;
		logic [63:0] pdo_data;
	} crx_state_type;

	crx_state_type s;
	crx_state_type next_s;

	logic [4:0] hit;
	logic [4:0] expired;
	logic [4:0] invalid;
	logic tick20;
	logic [5:0] wsel;
	logic [4:0] widx;
	logic acc;
	logic bad;
	logic [31:0] rdata;

	assign wsel = crx_word(paddr);
	assign widx = wsel[4:0];
	assign acc = psel && penable;
	assign tick20 = s.tick5 && (s.sub_cnt == 2'(CRX_PROC_TICKS - 1));

	// ------------------------------------------------------------
	// Per-PDO match and event timers
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < CRX_NUM_RPDO; g++) begin : g_pdo
			// Bit 31 set or not operational keeps the frame out
			assign invalid[g] = s.comm[g][CRX_VALID_BIT];
			assign hit[g] = rx_valid && nmt_operational && !invalid[g]
				&& rx_id == s.comm[g][10:0];
			crx_evt_timer u_tmr (
				.pclk(pclk),
				.presetn(presetn),
				.tick(s.tick5),
				.restart(hit[g]),
				.limit(crx_units(s.evt_ms[g])),
				.expired(expired[g])
			);
		end
	endgenerate

	// Read mux, latched in the setup phase so prdata comes from a flop
	always_comb begin
		rdata = '0;
		if (!wsel[5]) begin
			rdata = '0; // Unmapped words read as zero
		end else if (widx == CRX_W_NODE) begin
			rdata = {25'h0, s.node_id};
		end else if (widx < CRX_W_COMM) begin
			rdata = {25'h0, s.extra_id[2'(widx - CRX_W_EXTRA)]};
		end else if (widx < CRX_W_EVT) begin
			rdata = s.comm[3'(widx - CRX_W_COMM)];
		end else if (widx < CRX_W_ROUTE) begin
			rdata = {16'h0, s.evt_ms[3'(widx - CRX_W_EVT)]};
		end else if (widx == CRX_W_ROUTE) begin
			rdata = {22'h0, s.route};
		end else if (widx == CRX_W_STATUS) begin
			rdata = {22'h0, s.status};
		end else if (widx == CRX_W_MASK) begin
			rdata = {22'h0, s.mask};
		end else begin
			rdata = {27'h0, s.exist};
		end
	end

	// Out-of-range values and read-only words answer with an error
	always_comb begin
		bad = !wsel[5];
		if (wsel[5] && pwrite) begin
			if (widx == CRX_W_NODE) begin
				bad = pwdata[31:7] != '0 || pwdata[6:0] == '0;
			end else if (widx < CRX_W_COMM) begin
				bad = pwdata[31:7] != '0;
			end else if (widx < CRX_W_EVT) begin
				bad = pwdata == '0 || pwdata[CRX_ZERO_HI:CRX_ZERO_LO] != '0;
			end else if (widx < CRX_W_ROUTE) begin
				bad = pwdata[31:16] != '0 || pwdata[15:0] > CRX_EVT_MAX;
			end else if (widx == CRX_W_ROUTE) begin
				bad = pwdata[31:10] != '0;
			end else if (widx == CRX_W_MASK) begin
				bad = pwdata[31:10] != '0;
			end else begin
				bad = 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.sdo_req = 1'b0;
		next_s.pdo_strobe = 1'b0;
		next_s.tick5 = 1'b0;
		// 5 ms base tick; the 20 ms cadence is every fourth one
		if (s.div_cnt == CRX_DIV_W'(BASE_TICK_CYC - 1)) begin
			next_s.div_cnt = '0;
			next_s.tick5 = 1'b1;
		end else begin
			next_s.div_cnt = s.div_cnt + 1'b1;
		end
		if (s.tick5) begin
			next_s.sub_cnt = s.sub_cnt + 2'h1;
		end
		// SDO: primary first, then the open extra channels
		if (rx_valid && rx_id == CRX_SDO_RX_BASE + {4'h0, s.node_id}) begin
			next_s.sdo_req = 1'b1;
			next_s.sdo_chan = 3'h0;
			next_s.sdo_reply_id = CRX_SDO_TX_BASE + {4'h0, s.node_id};
			next_s.sdo_data = rx_data;
		end else begin
			for (int k = CRX_NUM_EXTRA - 1; k >= 0; k--) begin
				if (rx_valid && s.extra_id[k] != '0
					&& rx_id == CRX_SDO_RX_BASE + {4'h0, s.extra_id[k]}) begin
					next_s.sdo_req = 1'b1;
					next_s.sdo_chan = 3'(k + 1);
					next_s.sdo_reply_id = CRX_SDO_TX_BASE + {4'h0, s.extra_id[k]};
					next_s.sdo_data = rx_data;
				end
			end
		end
		// Drain held frames one per cycle after each 20 ms tick
		unique case (s.scan)
			CRX_IDLE: begin
				if (tick20) begin
					next_s.scan = CRX_SCAN;
					next_s.idx = 3'h0;
				end
			end
			CRX_SCAN: begin
				if (s.pend[s.idx]) begin
					next_s.pend[s.idx] = 1'b0;
					next_s.pdo_strobe = 1'b1;
					next_s.pdo_index = s.idx;
					next_s.pdo_route = s.route[s.idx];
					next_s.pdo_data = s.held[s.idx];
				end
				if (s.idx == 3'(CRX_NUM_RPDO - 1)) begin
					next_s.scan = CRX_IDLE;
				end else begin
					next_s.idx = s.idx + 3'h1;
				end
			end
		endcase
		// Status read clears only what was snapshotted; new events win
		if (acc && !pwrite && wsel[5] && widx == CRX_W_STATUS) begin
			next_s.status = s.status & ~s.prdata[9:0];
		end
		for (int i = 0; i < CRX_NUM_RPDO; i++) begin
			if (expired[i]) begin
				next_s.exist[i] = 1'b0;
				next_s.status[i] = 1'b1;
			end
			if (hit[i]) begin
				next_s.exist[i] = 1'b1;
				// One frame per window is kept, later ones are dropped
				if (!next_s.pend[i]) begin
					next_s.pend[i] = 1'b1;
					next_s.held[i] = rx_data;
				end else begin
					next_s.status[5 + i] = 1'b1;
				end
			end
		end
		// APB setup snapshot and access-phase write
		if (psel && !penable) begin
			next_s.prdata = rdata;
		end
		if (acc && pwrite && !bad) begin
			if (widx == CRX_W_NODE) begin
				next_s.node_id = pwdata[6:0];
			end else if (widx < CRX_W_COMM) begin
				next_s.extra_id[2'(widx - CRX_W_EXTRA)] = pwdata[6:0];
			end else if (widx < CRX_W_EVT) begin
				next_s.comm[3'(widx - CRX_W_COMM)] = pwdata;
			end else if (widx < CRX_W_ROUTE) begin
				next_s.evt_ms[3'(widx - CRX_W_EVT)] = pwdata[15:0];
			end else if (widx == CRX_W_ROUTE) begin
				next_s.route = pwdata[9:0];
			end else begin
				next_s.mask = pwdata[9:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
			s.node_id <= CRX_NODE_RST;
			s.comm <= {CRX_NUM_RPDO{CRX_COMM_RST}};
			s.evt_ms <= {CRX_NUM_RPDO{CRX_EVT_RST}};
			s.scan <= CRX_IDLE;
		end else begin
			s <= next_s;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign prdata = s.prdata;
	assign pready = 1'b1;
	assign pslverr = acc && bad;
	assign irq = |(s.status & s.mask);
	assign sdo_req = s.sdo_req;
	assign sdo_chan = s.sdo_chan;
	assign sdo_reply_id = s.sdo_reply_id;
	assign sdo_data = s.sdo_data;
	assign pdo_strobe = s.pdo_strobe;
	assign pdo_index = s.pdo_index;
	assign pdo_route = s.pdo_route;
	assign pdo_data = s.pdo_data;
	assign pdo_exist = s.exist;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_primary;
		rx_valid && rx_id == CRX_SDO_RX_BASE + {4'h0, s.node_id}
		|=> sdo_req && sdo_chan == 3'h0;
	endproperty
	a_primary: assert property (p_primary) else $error("primary SDO missed");

	property p_extra_open;
		sdo_req && sdo_chan != 3'h0 |-> sdo_reply_id != CRX_SDO_TX_BASE;
	endproperty
	a_extra_open: assert property (p_extra_open) else $error("closed channel answered");

	property p_reply_id;
		sdo_req |-> sdo_reply_id == $past(rx_id) - CRX_SDO_RX_BASE + CRX_SDO_TX_BASE;
	endproperty
	a_reply_id: assert property (p_reply_id) else $error("wrong reply id");

	property p_invalid_ignored;
		(s.pend & ~$past(s.pend) & $past(invalid)) == '0;
	endproperty
	a_invalid_ignored: assert property (p_invalid_ignored) else $error("invalid PDO held");

	property p_not_oper;
		!nmt_operational |=> (s.pend & ~$past(s.pend)) == '0;
	endproperty
	a_not_oper: assert property (p_not_oper) else $error("PDO taken outside operation");

	property p_comm_shape;
		s.comm[0] != '0 && s.comm[4][CRX_ZERO_HI:CRX_ZERO_LO] == '0;
	endproperty
	a_comm_shape: assert property (p_comm_shape) else $error("comm word out of range");

	property p_expire;
		expired[0] && !hit[0] |=> !pdo_exist[0] && s.status[0];
	endproperty
	a_expire: assert property (p_expire) else $error("timeout not marked");

	property p_round;
		32'(crx_units(s.evt_ms[1])) * 5 >= 32'(s.evt_ms[1])
		&& 32'(crx_units(s.evt_ms[1])) * 5 < 32'(s.evt_ms[1]) + 5;
	endproperty
	a_round: assert property (p_round) else $error("bad rounding");

	property p_cadence;
		$rose(s.scan == CRX_SCAN) |-> $past(tick20);
	endproperty
	a_cadence: assert property (p_cadence) else $error("scan off cadence");

	property p_route;
		pdo_strobe |-> pdo_route == $past(s.route[s.idx]) && $past(s.scan) == CRX_SCAN;
	endproperty
	a_route: assert property (p_route) else $error("route mismatch");

	c_sdo_extra: cover property (sdo_req && sdo_chan == 3'h4);
	c_pdo_out: cover property (pdo_strobe && pdo_index == 3'h2);
	c_discard: cover property ($rose(s.status[5]));
	c_timeout: cover property ($fell(pdo_exist[0]));
endmodule // crx_node

`default_nettype wire

// ===== crx_master_model.sv
// Behavioural CAN master that presents received frames to the node
`timescale 1ns/100ps
`default_nettype none

module crx_master_model (
	input wire logic pclk,
	output logic rx_valid,
	output logic [10:0] rx_id,
	output logic [63:0] rx_data,
	output logic nmt_operational
);
	// ------------------------------------------------------------
	// Idle state
	// ------------------------------------------------------------
	// Bus starts idle, node held in pre-operational
	initial begin
		rx_valid = 1'b0;
		rx_id = 11'h000;
		rx_data = 64'h0;
		nmt_operational = 1'b0;
	end

	// ------------------------------------------------------------
	// Frames and network commands
	// ------------------------------------------------------------
	// Each master sends on its own node id, ids kept in the allowed range
	// Lossless bench link, so no master ever needs to retry
	// Frame gaps stay far apart relative to the event timer
	// Released lines carry the inverse so stale values never look valid
	task automatic send(input logic [10:0] id, input logic [63:0] data);
		@(posedge pclk);
		rx_valid <= 1'b1;
		rx_id <= id;
		rx_data <= data;
		@(posedge pclk);
		rx_valid <= 1'b0;
		rx_id <= ~id;
		rx_data <= ~data;
	endtask

	// Operational state is commanded from outside
	task automatic set_op(input logic on);
		@(posedge pclk);
		nmt_operational <= on;
	endtask
endmodule // crx_master_model

`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the CAN receive node
`timescale 1ns/100ps
`default_nettype none

module testbench;
	import crx_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, irq, nmt_operational, rx_valid;
	logic [10:0] rx_id, sdo_reply_id;
	logic [63:0] rx_data, sdo_data, pdo_data;
	logic sdo_req, pdo_strobe;
	logic [2:0] sdo_chan, pdo_index;
	logic [1:0] pdo_route;
	logic [4:0] pdo_exist;
	int n_errors = 0;
	int num_checks = 0;
	int cyc = 0;
	logic [31:0] rd;
	logic err;
	int i;
	int n;
	int n_strobe = 0;
	// Ordinary register cases: address, write data, refused, readback
	logic [7:0] t_a [8] = '{8'h04, 8'h08, 8'h14, 8'h14, 8'h14, 8'h28, 8'h28, 8'h3C};
	logic [31:0] t_d [8] = '{32'h5, 32'h80, 32'h0, 32'h800, 32'h60000200,
		32'hFFDD, 32'hFFDC, 32'h2};
	logic t_e [8] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
	logic [31:0] t_r [8] = '{32'h5, 32'h0, 32'h80000000, 32'h80000000, 32'h60000200,
		32'h7D0, 32'hFFDC, 32'h2};

	// Short base tick keeps the 20 ms cadence at 80 cycles
	crx_node #(.BASE_TICK_CYC(20)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.nmt_operational(nmt_operational), .rx_valid(rx_valid), .rx_id(rx_id),
		.rx_data(rx_data), .sdo_req(sdo_req), .sdo_chan(sdo_chan),
		.sdo_reply_id(sdo_reply_id), .sdo_data(sdo_data), .pdo_strobe(pdo_strobe),
		.pdo_index(pdo_index), .pdo_route(pdo_route), .pdo_data(pdo_data),
		.pdo_exist(pdo_exist));
	crx_master_model mstr (.pclk(pclk), .rx_valid(rx_valid), .rx_id(rx_id),
		.rx_data(rx_data), .nmt_operational(nmt_operational));

	// ------------------------------------------------------------
	// Clock, timeout and helpers
	// ------------------------------------------------------------
	// 200 MHz clock
	always #2.5 pclk = ~pclk;

	// Hang guard, well above the expected run length
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			tally_and_finish();
		end
	end

	// Count deliveries so a one-cycle strobe is never missed
	always @(posedge pclk) begin
		if (pdo_strobe === 1'b1) n_strobe <= n_strobe + 1;
	end

	task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	// One APB transfer; waits for pready, samples at that edge only
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic sdo_case(input logic [10:0] id, input logic rq, input logic [13:0] ch_rep);
		mstr.send(id, 64'h0123_4567_89AB_CDEF);
		#1;
		chk("sdo_req", rq, sdo_req);
		if (rq) chk("sdo_chan_reply", ch_rep, {sdo_chan, sdo_reply_id});
		if (rq) chk("sdo_data", 64'h0123_4567_89AB_CDEF, sdo_data);
	endtask

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 8'h18, 32'h0);
		chk("comm1_rst", 32'h80000000, rd);
		apb(1'b0, 8'h2C, 32'h0);
		chk("evt1_rst", 32'h7D0, rd);
		apb(1'b0, 8'h4C, 32'h0);
		chk("unmapped_err", 1'b1, err);
		chk("unmapped_rd", 32'h0, rd);
		// Table of register writes with readback
		for (i = 0; i < 8; i++) begin
			apb(1'b1, t_a[i], t_d[i]);
			chk("wr_err", t_e[i], err);
			apb(1'b0, t_a[i], 32'h0);
			chk("readback", t_r[i], rd);
		end
		// SDO channels: primary 1, extra 5, closed id 0
		sdo_case(11'h601, 1'b1, {3'h0, 11'h581});
		sdo_case(11'h605, 1'b1, {3'h1, 11'h585});
		sdo_case(11'h600, 1'b0, 14'h0);
		// Not operational: frame ignored
		mstr.send(11'h200, 64'h11);
		#1;
		chk("exist_preop", 5'h00, pdo_exist);
		mstr.set_op(1'b1);
		// Invalid RPDO1 ignored while operational
		apb(1'b1, 8'h18, 32'h80000201);
		mstr.send(11'h201, 64'h22);
		#1;
		chk("exist_invalid", 5'h00, pdo_exist);
		// Two frames in one window: second discarded, first delivered
		apb(1'b0, 8'h40, 32'h0);
		mstr.send(11'h200, 64'hA5A5);
		#1;
		chk("exist_rx", 5'h01, pdo_exist);
		mstr.send(11'h200, 64'h5A5A);
		apb(1'b0, 8'h40, 32'h0);
		chk("status_discard", 32'h20, rd);
		apb(1'b0, 8'h40, 32'h0);
		chk("status_clear", 32'h0, rd);
		n = 0;
		while (n_strobe < 1 && n < 200) begin
			@(posedge pclk);
			#1;
			n++;
		end
		chk("strobe_count", 32'h1, n_strobe);
		chk("pdo_delivery", {3'h0, 2'h2, 64'hA5A5}, {pdo_index, pdo_route, pdo_data});
		// Timeout: 7 ms rounds to two 5 ms ticks of 20 cycles
		apb(1'b1, 8'h28, 32'h7);
		apb(1'b1, 8'h44, 32'h1);
		mstr.send(11'h200, 64'h33);
		n = 0;
		while (pdo_exist[0] !== 1'b0 && n < 200) begin
			@(posedge pclk);
			#1;
			n++;
		end
		chk("timeout_window", 1'b1, n >= 2 * 20 && n <= 3 * 20 + 3);
		chk("irq_set", 1'b1, irq);
		apb(1'b0, 8'h40, 32'h0);
		chk("status_timeout", 32'h1, rd);
		@(posedge pclk);
		#1;
		chk("irq_clear", 1'b0, irq);
		// Mid-run reset: outputs clear, configuration returns to defaults
		@(posedge pclk);
		presetn <= 1'b0;
		@(posedge pclk);
		#1;
		chk("reset_outputs", 9'h0, {irq, sdo_req, pdo_strobe, pdo_exist, pslverr});
		@(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 8'h00, 32'h0);
		chk("node_rst", 32'h1, rd);
		apb(1'b0, 8'h14, 32'h0);
		chk("comm0_rst", 32'h80000000, rd);
		apb(1'b0, 8'h28, 32'h0);
		chk("evt0_rst", 32'h7D0, rd);
		tally_and_finish();
	end
endmodule // testbench

`default_nettype wire
